// file: shared/nvm_ctrl_pkg.sv
// Package for the program-memory control register front end.
// Assumes a single bus clock domain and AHB-Lite register access.
package nvm_ctrl_pkg;
    localparam logic [11:0] ADDR_CLOCK_DIVIDER = 12'h000;
    localparam logic [11:0] ADDR_PROTECTION = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_COMMAND = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
    localparam logic [11:0] ADDR_DEBUG_PROT = 12'h018;
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam int LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int CBEF_BIT = 7;
    localparam int CCF_BIT = 6;
    localparam int PROT_DIS_BIT = 0;
    localparam int ADDR_WIDTH = 14;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
    localparam logic [7:0] STATUS_READ_MASK = 8'hF4;
    localparam logic [3:0] PULSES_PER_OP = 4'h4;
    localparam logic [1:0] IRQ_DONE = 2'h1;
    localparam logic [1:0] IRQ_REJECT = 2'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_NEXT = 3'b100
    } seq_state_t;
endpackage : nvm_ctrl_pkg

// file: core/nvm_ctrl.sv
// Register front end: clock divider, block protection, command status.
// Assumes AHB-Lite single-word transfers on i_clock, async low reset.
// Overview of operation
// - Divider bit seven read-only, low bits write-once
// - Loaded flag set by first divider write
// - No program or erase before divider loaded
// - Bit six selects divide-by-eight prescaler
// - Divide selected clock by divisor plus one
// - Operations take whole timing clock pulses
// - Protection loaded from nonvolatile byte on the first clock after reset release
// - Select field sets end of unprotected region
// - Reject program or erase in protected block
// - Bit zero disables protection entirely
// - Debug port may alter protection bits
// - Status bits 3,1,0 read zero, ignore writes
// - Writing one to empty flag launches command
// - Only burst program commands are buffered
// - Complete flag tracks idle empty controller
// - Writes to complete flag are ignored
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic [7:0] i_nv_protection,
    input wire logic i_dbg_prot_we,
    input wire logic [7:0] i_dbg_prot_data,
    output logic o_timing_tick,
    output logic o_array_pulse,
    output logic [nvm_ctrl_pkg::ADDR_WIDTH-1:0] o_array_addr,
    output logic [7:0] o_array_cmd,
    output logic o_irq
);
    import nvm_ctrl_pkg::*;

    logic [7:0] clock_divider;
    logic [7:0] protection;
    logic prot_loaded;
    logic cbef;
    logic ccf;
    logic [7:0] cmd_reg;
    logic [ADDR_WIDTH-1:0] cmd_addr;
    logic buf_full;
    logic [7:0] buf_cmd;
    logic [ADDR_WIDTH-1:0] buf_addr;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [2:0] prescale_cnt;
    logic [5:0] div_cnt;
    logic [3:0] pulse_cnt;
    seq_state_t state;

    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    logic wr_div, wr_prot_dbg, wr_status, wr_cmd, wr_irqs, wr_mask;
    logic launch, accept_buf, blocked, in_protected, prescale_tick;
    logic [ADDR_WIDTH-1:0] req_addr;
    logic [7:0] req_cmd;
    logic blocked_reg;
    logic [ADDR_WIDTH-1:0] prot_bound;

    // Zero-wait slave, response always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 12'h000;
        end else if (i_hready) begin
            ph_valid <= i_hsel && i_htrans == HTRANS_NONSEQ;
            ph_write <= i_hwrite;
            ph_addr <= i_haddr[11:0];
        end
    end

    assign wr_div = ph_valid && ph_write && ph_addr == ADDR_CLOCK_DIVIDER;
    assign wr_status = ph_valid && ph_write && ph_addr == ADDR_STATUS;
    assign wr_cmd = ph_valid && ph_write && ph_addr == ADDR_COMMAND;
    assign wr_irqs = ph_valid && ph_write && ph_addr == ADDR_IRQ_STATUS;
    assign wr_mask = ph_valid && ph_write && ph_addr == ADDR_IRQ_MASK;
    assign wr_prot_dbg = ph_valid && ph_write && ph_addr == ADDR_DEBUG_PROT;

    // Write-once divider; flag marks the first write
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clock_divider <= DIVIDER_RESET;
        end else if (wr_div && !clock_divider[LOADED_BIT]) begin
            clock_divider <= {1'b1, i_hwdata[6:0]};
        end
    end

    // Strap caught after release, never under reset
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            protection <= 8'h00;
            prot_loaded <= 1'b0;
        end else if (!prot_loaded) begin
            protection <= i_nv_protection;
            prot_loaded <= 1'b1;
        end else if (i_dbg_prot_we) begin
            protection <= i_dbg_prot_data;
        end else if (wr_prot_dbg) begin
            protection <= i_hwdata[7:0];
        end
    end

    // Prescaler and divisor counter make the timing tick
    assign prescale_tick = !clock_divider[PRESCALE_BIT]
        || prescale_cnt == PRESCALE_LAST;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prescale_cnt <= 3'h0;
            div_cnt <= 6'h00;
            o_timing_tick <= 1'b0;
        end else begin
            prescale_cnt <= prescale_cnt + 3'h1;
            o_timing_tick <= 1'b0;
            if (prescale_tick) begin
                if (div_cnt >= clock_divider[5:0]) begin
                    div_cnt <= 6'h00;
                    o_timing_tick <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 6'h01;
                end
            end
        end
    end

    // Boundary: unprotected space ends below select field address
    assign prot_bound = {protection[7:1], {(ADDR_WIDTH-7){1'b0}}};
    assign req_addr = i_hwdata[8 +: ADDR_WIDTH];
    assign req_cmd = i_hwdata[7:0];
    assign in_protected = !protection[PROT_DIS_BIT]
        && req_addr >= prot_bound;
    assign blocked = !clock_divider[LOADED_BIT] || in_protected;
    assign launch = wr_status && i_hwdata[CBEF_BIT] && cbef && !blocked_reg
        && (state != ST_RUN || cmd_reg == CMD_BURST_PROGRAM);
    assign accept_buf = launch && state == ST_RUN;

    // Command staging: address and command written to the command register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_reg <= 8'h00;
            cmd_addr <= '0;
            blocked_reg <= 1'b1;
        end else if (wr_cmd && cbef) begin
            cmd_reg <= req_cmd;
            cmd_addr <= req_addr;
            blocked_reg <= blocked;
        end
    end

    // Sequencer runs a whole number of timing pulses
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            pulse_cnt <= 4'h0;
            o_array_addr <= '0;
            o_array_cmd <= 8'h00;
            o_array_pulse <= 1'b0;
            buf_full <= 1'b0;
            buf_cmd <= 8'h00;
            buf_addr <= '0;
        end else begin
            o_array_pulse <= 1'b0;
            if (accept_buf) begin
                buf_full <= 1'b1;
                buf_cmd <= cmd_reg;
                buf_addr <= cmd_addr;
            end
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        state <= ST_RUN;
                        o_array_cmd <= cmd_reg;
                        o_array_addr <= cmd_addr;
                        pulse_cnt <= 4'h0;
                    end
                end
                ST_RUN: begin
                    if (o_timing_tick) begin
                        o_array_pulse <= 1'b1;
                        pulse_cnt <= pulse_cnt + 4'h1;
                        if (pulse_cnt == PULSES_PER_OP - 4'h1) begin
                            state <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    if (buf_full) begin
                        state <= ST_RUN;
                        o_array_cmd <= buf_cmd;
                        o_array_addr <= buf_addr;
                        pulse_cnt <= 4'h0;
                        buf_full <= 1'b0;
                    end else if (launch) begin
                        state <= ST_RUN;
                        o_array_cmd <= cmd_reg;
                        o_array_addr <= cmd_addr;
                        pulse_cnt <= 4'h0;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Empty flag: cleared on launch, set when buffer frees
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cbef <= 1'b1;
        end else if (launch) begin
            cbef <= 1'b0;
        end else if (state == ST_NEXT && buf_full) begin
            cbef <= 1'b1;
        end else if (!buf_full) begin
            // Empty again once the array holds the command
            cbef <= 1'b1;
        end
    end

    // Complete flag derived by hardware only; writes ignored
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ccf <= 1'b1;
        end else if (launch) begin
            ccf <= 1'b0;
        end else if (state == ST_IDLE && cbef && !buf_full) begin
            ccf <= 1'b1;
        end
    end

    // Sticky events; set wins over write-one-to-clear
    logic done_evt, reject_evt;
    // A launch in the gap between operations is not completion
    assign done_evt = state == ST_NEXT && !buf_full && !launch;
    assign reject_evt = wr_status && i_hwdata[CBEF_BIT] && cbef
        && blocked_reg;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
        end else begin
            irq_status <= (irq_status & ~(wr_irqs ? i_hwdata[1:0] : 2'h0))
                | (done_evt ? IRQ_DONE : 2'h0)
                | (reject_evt ? IRQ_REJECT : 2'h0);
            if (wr_mask) begin
                irq_mask <= i_hwdata[1:0];
            end
        end
    end
    assign o_irq = |(irq_status & irq_mask);

    // Read data driven combinationally in data phase
    always_comb begin
        o_hrdata = 32'h0000_0000;
        if (ph_valid && !ph_write) begin
            case (ph_addr)
                ADDR_CLOCK_DIVIDER: o_hrdata = {24'h0, clock_divider};
                ADDR_PROTECTION: o_hrdata = {24'h0, protection};
                ADDR_STATUS: o_hrdata = {24'h0,
                    {cbef, ccf, 6'h00} & STATUS_READ_MASK};
                ADDR_COMMAND: o_hrdata = {10'h0, cmd_addr, cmd_reg};
                ADDR_IRQ_STATUS: o_hrdata = {30'h0, irq_status};
                ADDR_IRQ_MASK: o_hrdata = {30'h0, irq_mask};
                default: o_hrdata = 32'h0000_0000;
            endcase
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence first_div_write_s;
        wr_div && !clock_divider[LOADED_BIT];
    endsequence

    sequence idle_launch_s;
        state == ST_IDLE && launch;
    endsequence

    sequence buf_move_s;
        state == ST_NEXT && buf_full;
    endsequence

    div_once_a: assert property (
        wr_div && clock_divider[LOADED_BIT] |=> $stable(clock_divider))
        else $error("divider changed after first write");
    div_loaded_a: assert property (
        first_div_write_s |=> clock_divider[LOADED_BIT]
            && clock_divider[6:0] == $past(i_hwdata[6:0]))
        else $error("divider flag not set by first write");
    no_launch_a: assert property (
        !clock_divider[LOADED_BIT] |-> !launch)
        else $error("launch before divider loaded");
    tick_fast_a: assert property (
        o_timing_tick && !clock_divider[PRESCALE_BIT]
            && clock_divider[5:0] == 6'h01 |=> !o_timing_tick ##1 o_timing_tick)
        else $error("divider period wrong");
    pulse_tick_a: assert property (
        o_array_pulse |-> $past(o_timing_tick))
        else $error("array pulse not on timing tick");
    protect_reject_a: assert property (
        launch |-> !blocked_reg)
        else $error("protected launch accepted");
    launch_clear_a: assert property (
        launch |=> !cbef && !ccf)
        else $error("launch did not clear flags");
    status_zero_a: assert property (
        ph_valid && !ph_write && ph_addr == ADDR_STATUS
            |-> o_hrdata[3] == 1'b0 && o_hrdata[1:0] == 2'h0)
        else $error("reserved status bit nonzero");
    ccf_idle_a: assert property (
        state == ST_RUN |-> !ccf)
        else $error("complete flag set while running");
    buf_accept_a: assert property (
        accept_buf |=> buf_full && !cbef)
        else $error("burst command not buffered");
    buf_move_a: assert property (
        buf_move_s |=> state == ST_RUN && cbef && !buf_full)
        else $error("buffered command not moved to array");
    burst_only_a: assert property (
        buf_full |-> buf_cmd == CMD_BURST_PROGRAM)
        else $error("non-burst command in buffer");
    cbef_refill_a: assert property (
        idle_launch_s |=> !cbef ##1 cbef)
        else $error("empty flag not refilled after start");
    cbef_reject_a: assert property (
        reject_evt |=> cbef)
        else $error("refused launch cleared empty flag");
    reject_irq_a: assert property (
        reject_evt |=> (irq_status & IRQ_REJECT) != 2'h0)
        else $error("refusal event not recorded");
    done_irq_a: assert property (
        done_evt |=> (irq_status & IRQ_DONE) != 2'h0)
        else $error("completion event not recorded");
    ccf_set_a: assert property (
        state == ST_IDLE && cbef && !buf_full && !launch
            |=> ccf)
        else $error("complete flag not set when idle");
    prot_load_a: assert property (
        !prot_loaded |=> protection == $past(i_nv_protection))
        else $error("protection not loaded from strap");
    prot_debug_a: assert property (
        prot_loaded && i_dbg_prot_we
            |=> protection == $past(i_dbg_prot_data))
        else $error("debug protection write lost");
    // Divide-by-eight path leaves at least seven quiet cycles
    tick_prescale_a: assert property (
        o_timing_tick && clock_divider[PRESCALE_BIT]
            |=> !o_timing_tick [*7])
        else $error("prescaled tick too early");
endmodule : nvm_ctrl
`default_nettype wire

// file: tb/nvm_cpu_model.sv
// CPU side of the register bus: single-word AHB-Lite master.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module nvm_cpu_model (
    input wire logic i_clock,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    import nvm_ctrl_pkg::*;
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end
    // Bounded waits so a stuck slave shows up as a failed handshake
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic ok);
        int n;
        @(posedge i_clock);
        o_hsel <= 1'b1;
        o_haddr <= {20'h00000, a};
        o_htrans <= HTRANS_NONSEQ;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (i_hready !== 1'b1 && n < 16);
        ok = (n < 16);
        o_htrans <= 2'h0;
        o_hsel <= 1'b0;
        o_hwdata <= wd;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (i_hready !== 1'b1 && n < 16);
        rd = i_hrdata;
        ok = ok && (n < 16);
    endtask : xfer
endmodule : nvm_cpu_model
`default_nettype wire

// file: tb/test_flash_ctrl_clock_protect_status.sv
// Self-checking bench for the program-memory control registers.
// Assumes the package offsets and a zero-wait register slave.
`timescale 1ns/1ps
`default_nettype none
module test_flash_ctrl_clock_protect_status;
    import nvm_ctrl_pkg::*;
    localparam logic [7:0] NV_BYTE = 8'h80;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic hsel, hwrite, hready, hresp, irq, tick, apulse, dbg_we;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] dbg_data, acmd;
    logic [ADDR_WIDTH-1:0] aaddr;
    int miscompares = 0;
    int checks = 0;
    int pulse_count = 0;
    always #2 i_clock = ~i_clock;
    always @(posedge i_clock) if (apulse === 1'b1) pulse_count <= pulse_count + 1;
    nvm_cpu_model i_cpu (.i_clock(i_clock), .i_hready(hready),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
    nvm_ctrl i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_nv_protection(NV_BYTE), .i_dbg_prot_we(dbg_we),
        .i_dbg_prot_data(dbg_data), .o_timing_tick(tick),
        .o_array_pulse(apulse), .o_array_addr(aaddr), .o_array_cmd(acmd),
        .o_irq(irq));
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        logic ok;
        i_cpu.xfer(w, a, d, rd, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] bus handshake expected ready seen none");
            report_and_stop();
        end
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] exp, input string name);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        chk(name, exp, rd & m);
    endtask : rd_chk
    // Counter cleared while idle, so no pulse can race the clear
    task automatic launch(input logic [13:0] a);
        wr(ADDR_COMMAND, {10'h000, a, CMD_BURST_PROGRAM});
        pulse_count = 0;
        wr(ADDR_STATUS, 32'h80);
    endtask : launch
    task automatic tick_period(output int p);
        int n;
        for (n = 0; n < 200 && tick !== 1'b1; n++) @(posedge i_clock);
        @(posedge i_clock);
        for (p = 1; p < 200 && tick !== 1'b1; p++) @(posedge i_clock);
    endtask : tick_period
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        int p;
        dbg_we = 1'b0;
        dbg_data = 8'h00;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        rd_chk(ADDR_CLOCK_DIVIDER, 32'hFF, 32'h00, "divider");
        chk("hresp", 32'h0, {31'h0, hresp});
        rd_chk(ADDR_PROTECTION, 32'hFF, {24'h0, NV_BYTE}, "protection");
        rd_chk(ADDR_STATUS, 32'h4B, 32'h40, "status");
        rd_chk(12'h020, 32'hFFFFFFFF, 32'h0, "unmapped");
        $display("test reset done");
        launch(14'h0010);
        repeat (40) @(posedge i_clock);
        chk("pulses", 32'h0, pulse_count);
        rd_chk(ADDR_IRQ_STATUS, 32'h3, {30'h0, IRQ_REJECT}, "irq");
        wr(ADDR_IRQ_MASK, 32'h3);
        @(posedge i_clock);
        chk("irq out", 32'h1, {31'h0, irq});
        wr(ADDR_IRQ_STATUS, 32'h3);
        @(posedge i_clock);
        chk("irq out", 32'h0, {31'h0, irq});
        $display("test unloaded refusal done");
        // Divisor kept tiny; real parts need far slower timing clocks
        wr(ADDR_CLOCK_DIVIDER, 32'h41);
        rd_chk(ADDR_CLOCK_DIVIDER, 32'hFF, 32'hC1, "divider");
        wr(ADDR_CLOCK_DIVIDER, 32'h05);
        rd_chk(ADDR_CLOCK_DIVIDER, 32'hFF, 32'hC1, "divider");
        tick_period(p);
        chk("tick period", 32'(8 * (1 + 1)), p);
        $display("test divider done");
        launch(14'h2000);
        repeat (40) @(posedge i_clock);
        rd_chk(ADDR_IRQ_STATUS, 32'h3, {30'h0, IRQ_REJECT}, "irq");
        wr(ADDR_IRQ_STATUS, 32'h3);
        launch(14'h1FFF);
        rd_chk(ADDR_STATUS, 32'hC0, 32'h80, "status busy");
        chk("array addr", 32'h1FFF, {18'h0, aaddr});
        chk("array cmd", {24'h0, CMD_BURST_PROGRAM}, {24'h0, acmd});
        wr(ADDR_COMMAND, {10'h000, 14'h1FFE, CMD_BURST_PROGRAM});
        wr(ADDR_STATUS, 32'h80);
        rd_chk(ADDR_STATUS, 32'hC0, 32'h00, "status full");
        repeat (200) @(posedge i_clock);
        chk("pulses", 32'(2 * PULSES_PER_OP), pulse_count);
        rd_chk(ADDR_STATUS, 32'hC0, 32'hC0, "status idle");
        rd_chk(ADDR_IRQ_STATUS, 32'h3, {30'h0, IRQ_DONE}, "irq");
        wr(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'h4B);
        rd_chk(ADDR_STATUS, 32'hCB, 32'hC0, "status");
        $display("test protection done");
        @(posedge i_clock);
        dbg_data <= 8'h81;
        dbg_we <= 1'b1;
        @(posedge i_clock);
        dbg_we <= 1'b0;
        rd_chk(ADDR_PROTECTION, 32'hFF, 32'h81, "protection");
        launch(14'h3000);
        repeat (120) @(posedge i_clock);
        chk("pulses", {28'h0, PULSES_PER_OP}, pulse_count);
        rd_chk(ADDR_IRQ_STATUS, 32'h3, {30'h0, IRQ_DONE}, "irq");
        $display("test debug protection done");
        report_and_stop();
    end
endmodule : test_flash_ctrl_clock_protect_status
`default_nettype wire
